// ---- src/vpc_ctrl.sv ----
// Voice playback control: buttons, one-wire and three-wire command front end.
// Assumes the playback engine pulses seg_end_i when a started segment finishes.
// How it works
// - repeating edge mode: every falling edge restarts the button's segment.
// - non-repeating edge mode: falling edges during playback are ignored.
// - looping level mode: replay while held low, stop on release.
// - single-shot level mode: play once while low, stop on release.
// - non-maintained loop: release does not cut; replay at end if still low.
// - play/stop mode: pulses alternately start and stop playback.
// - non-wrapping next: each pulse plays next segment, sticks at the last.
// - non-wrapping previous: each pulse plays previous segment, sticks at the first.
// - wrapping next: after the last segment wrap to the first.
// - wrapping previous: before the first segment wrap to the last.
// - pause mode: pulses toggle run and suspend; busy holds while suspended.
// - stop mode: a pulse halts playback, no effect when idle.
// - one-wire bit: high then low; long high is one, short high is zero.
// - serial bytes travel least significant bit first.
// - bytes 00H to DBH play that segment at once.
// - bytes E0H to E7H set volume, idle or playing.
// - F2H during playback makes the segment repeat.
// - FEH stops the segment playing.
// - busy responds within 20ms of a received byte.
// - three-wire mode ignores buttons; lines one, two, three carry data, select, clock.
// - button inputs are debounced for about 10ms.
// - three-wire data is sampled on rising clock, LSB first.
`timescale 1ns/100ps
`default_nettype none
module vpc_ctrl
  import vpc_pkg::*;
#(
  parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
  parameter int unsigned SYNC_CYC = SYNC_MIN_CYC
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Configuration
  input  wire logic [1:0] ctrl_mode_i,
  input  wire logic [3:0] trig_mode_a_i,
  input  wire logic [3:0] trig_mode_b_i,
  input  wire logic [3:0] trig_mode_c_i,
  // Port lines
  input  wire logic       port_line_zero_i,
  input  wire logic       port_line_one_i,
  input  wire logic       port_line_two_i,
  input  wire logic       port_line_three_i,
  // Playback engine
  input  wire logic       seg_end_i,
  output logic            play_start_o,
  output logic [7:0]      seg_o,
  output logic            paused_o,
  output logic            loop_o,
  output logic [2:0]      volume_o,
  output logic            busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once the second and third stages agree
  logic [3:0] pin_w;
  logic [3:0] s1_q, s2_q, s3_q, lvl_q;
  assign pin_w = {port_line_three_i, port_line_two_i, port_line_one_i, port_line_zero_i};

  for (genvar p = 0; p < 4; p++) begin : g_sync
    logic lvl_d;
    always_comb begin
      lvl_d = (s2_q[p] == s3_q[p]) ? s3_q[p] : lvl_q[p];
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        s1_q[p]  <= 1'b1;
        s2_q[p]  <= 1'b1;
        s3_q[p]  <= 1'b1;
        lvl_q[p] <= 1'b1;
      end else begin
        s1_q[p]  <= pin_w[p];
        s2_q[p]  <= s1_q[p];
        s3_q[p]  <= s2_q[p];
        lvl_q[p] <= lvl_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Button debounce and edge detection
  logic [2:0]       deb_q, deb_p_q, fall_w, rise_w;
  logic [DEB_W-1:0] db_cnt_q [3];

  for (genvar k = 0; k < 3; k++) begin : g_deb
    logic [DEB_W-1:0] cnt_d;
    logic             deb_d;
    always_comb begin
      cnt_d = '0;
      deb_d = deb_q[k];
      if (lvl_q[k] != deb_q[k]) begin
        if (db_cnt_q[k] == DEB_W'(DEB_CYC - 1)) begin
          deb_d = lvl_q[k];
        end else begin
          cnt_d = db_cnt_q[k] + 1'b1;
        end
      end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        db_cnt_q[k] <= '0;
        deb_q[k]    <= 1'b1;
        deb_p_q[k]  <= 1'b1;
      end else begin
        db_cnt_q[k] <= cnt_d;
        deb_q[k]    <= deb_d;
        deb_p_q[k]  <= deb_q[k];
      end
    end
    // Buttons are dead in three-wire mode
    assign fall_w[k] = deb_p_q[k] & ~deb_q[k] & (ctrl_mode_i != CM_THREE);
    assign rise_w[k] = ~deb_p_q[k] & deb_q[k] & (ctrl_mode_i != CM_THREE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receivers: one-wire pulse width and three-wire clocked
  vpc_ow_e        ow_st_q, ow_st_d;
  logic [OW_W-1:0] ow_cnt_q, ow_cnt_d, ow_hi_q, ow_hi_d;
  logic           ow_p_q, tw_clk_p_q;
  logic [7:0]     sh_q, sh_d;
  logic [2:0]     nbit_q, nbit_d;
  logic           rx_vld_q, rx_vld_d;
  logic [7:0]     rx_byte_q, rx_byte_d;
  logic           ow_rise, ow_fall, tw_rise;

  assign ow_rise = ~ow_p_q & lvl_q[3];
  assign ow_fall = ow_p_q & ~lvl_q[3];
  assign tw_rise = ~tw_clk_p_q & lvl_q[3];

  always_comb begin
    ow_st_d   = ow_st_q;
    ow_cnt_d  = (ow_cnt_q == OW_CNT_MAX) ? ow_cnt_q : ow_cnt_q + 1'b1;
    ow_hi_d   = ow_hi_q;
    sh_d      = sh_q;
    nbit_d    = nbit_q;
    rx_vld_d  = 1'b0;
    rx_byte_d = rx_byte_q;
    if (ctrl_mode_i == CM_ONE) begin
      case (ow_st_q)
        OW_IDLE: begin
          if (ow_fall) begin
            ow_st_d  = OW_SYNC;
            ow_cnt_d = '0;
          end
        end
        OW_SYNC: begin
          if (ow_rise) begin
            ow_st_d  = (ow_cnt_q >= OW_W'(SYNC_CYC)) ? OW_HI : OW_IDLE;
            ow_cnt_d = '0;
            nbit_d   = '0;
          end
        end
        OW_HI: begin
          if (ow_fall) begin
            ow_hi_d  = ow_cnt_q;
            ow_cnt_d = '0;
            ow_st_d  = OW_LO;
          end else if (ow_cnt_q >= OW_W'(SYNC_CYC)) begin
            ow_st_d = OW_IDLE;
          end
        end
        OW_LO: begin
          if (ow_rise) begin
            sh_d     = {(ow_hi_q > ow_cnt_q), sh_q[7:1]};
            nbit_d   = nbit_q + 1'b1;
            ow_cnt_d = '0;
            ow_st_d  = OW_HI;
            if (nbit_q == 3'h7) begin
              rx_vld_d  = 1'b1;
              rx_byte_d = {(ow_hi_q > ow_cnt_q), sh_q[7:1]};
              ow_st_d   = OW_IDLE;
            end
          end else if (ow_cnt_q >= OW_W'(SYNC_CYC)) begin
            // A long low is the next frame's start
            ow_st_d = OW_SYNC;
          end
        end
        default: ow_st_d = OW_IDLE;
      endcase
    end else begin
      ow_st_d = OW_IDLE;
      if (ctrl_mode_i == CM_THREE) begin
        if (lvl_q[2]) begin
          nbit_d = '0;
        end else if (tw_rise) begin
          sh_d   = {lvl_q[1], sh_q[7:1]};
          nbit_d = nbit_q + 1'b1;
          if (nbit_q == 3'h7) begin
            rx_vld_d  = 1'b1;
            rx_byte_d = {lvl_q[1], sh_q[7:1]};
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ow_st_q    <= OW_IDLE;
      ow_cnt_q   <= '0;
      ow_hi_q    <= '0;
      ow_p_q     <= 1'b1;
      tw_clk_p_q <= 1'b1;
      sh_q       <= '0;
      nbit_q     <= '0;
      rx_vld_q   <= 1'b0;
      rx_byte_q  <= '0;
    end else begin
      ow_st_q    <= ow_st_d;
      ow_cnt_q   <= ow_cnt_d;
      ow_hi_q    <= ow_hi_d;
      ow_p_q     <= lvl_q[3];
      tw_clk_p_q <= lvl_q[3];
      sh_q       <= sh_d;
      nbit_q     <= nbit_d;
      rx_vld_q   <= rx_vld_d;
      rx_byte_q  <= rx_byte_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Playback control
  vpc_play_e  st_q, st_d;
  logic [7:0] seg_q, seg_d, sel_q, sel_d, nxt;
  logic [1:0] own_q, own_d;
  logic       loop_q, loop_d, start_q, start_d, selv_q, selv_d;
  logic [2:0] vol_q, vol_d;
  logic       go, halt;
  logic [7:0] go_seg;
  logic [1:0] go_own;
  vpc_trig_e  tm [3];

  assign tm[0] = vpc_trig_e'(trig_mode_a_i);
  assign tm[1] = vpc_trig_e'(trig_mode_b_i);
  assign tm[2] = vpc_trig_e'(trig_mode_c_i);

  always_comb begin
    st_d = st_q; seg_d = seg_q; own_d = own_q; loop_d = loop_q; vol_d = vol_q;
    sel_d = sel_q; selv_d = selv_q; start_d = 1'b0;
    go = 1'b0; halt = 1'b0; go_seg = seg_q; go_own = own_q; nxt = sel_q;
    if (seg_end_i && st_q == ST_PLAY) begin
      if (loop_q || (own_q != OWN_SERIAL && !deb_q[own_q] &&
          (tm[own_q] == TM_LOOP_LVL || tm[own_q] == TM_NM_LOOP))) begin
        start_d = 1'b1;
      end else begin
        st_d = ST_IDLE;
      end
    end
    for (int k = 0; k < 3; k++) begin
      if (rise_w[k] && own_q == 2'(k) && st_q != ST_IDLE &&
          (tm[k] == TM_LOOP_LVL || tm[k] == TM_ONCE_LVL)) begin
        halt = 1'b1;
      end
      if (fall_w[k]) begin
        case (tm[k])
          TM_REP_EDGE, TM_LOOP_LVL, TM_ONCE_LVL, TM_NM_LOOP: begin
            go = 1'b1; go_seg = 8'(k); go_own = 2'(k); halt = 1'b0;
          end
          TM_NOREP_EDGE: begin
            if (st_q == ST_IDLE) begin
              go = 1'b1; go_seg = 8'(k); go_own = 2'(k);
            end
          end
          TM_PLAY_STOP: begin
            if (st_q == ST_IDLE) begin
              go = 1'b1; go_seg = 8'(k); go_own = 2'(k);
            end else begin
              halt = 1'b1;
            end
          end
          TM_NEXT_NW, TM_PREV_NW, TM_NEXT_W, TM_PREV_W: begin
            case (tm[k])
              TM_NEXT_NW: nxt = !selv_d ? SEG_FIRST : (sel_d < SEG_LAST) ? sel_d + 1'b1 : sel_d;
              TM_PREV_NW: nxt = !selv_d ? SEG_LAST : (sel_d > SEG_FIRST) ? sel_d - 1'b1 : sel_d;
              TM_NEXT_W:  nxt = (!selv_d || sel_d == SEG_LAST) ? SEG_FIRST : sel_d + 1'b1;
              default:    nxt = (!selv_d || sel_d == SEG_FIRST) ? SEG_LAST : sel_d - 1'b1;
            endcase
            sel_d = nxt; selv_d = 1'b1;
            go = 1'b1; go_seg = nxt; go_own = 2'(k);
          end
          TM_PAUSE: begin
            if (st_q == ST_IDLE) begin
              go = 1'b1; go_seg = 8'(k); go_own = 2'(k);
            end else begin
              st_d = (st_q == ST_PLAY) ? ST_PAUSE : ST_PLAY;
            end
          end
          TM_STOP: begin
            if (st_q != ST_IDLE) begin
              halt = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
    if (halt) begin
      st_d = ST_IDLE; loop_d = 1'b0; start_d = 1'b0;
    end
    if (go) begin
      st_d = ST_PLAY; seg_d = go_seg; own_d = go_own; loop_d = 1'b0; start_d = 1'b1;
    end
    // Serial commands take priority over buttons in the same cycle
    if (rx_vld_q) begin
      if (rx_byte_q <= SEG_LAST) begin
        st_d = ST_PLAY; seg_d = rx_byte_q; own_d = OWN_SERIAL;
        loop_d = 1'b0; start_d = 1'b1;
      end else if (rx_byte_q >= VOL_FIRST && rx_byte_q <= VOL_LAST) begin
        vol_d = rx_byte_q[2:0];
      end else if (rx_byte_q == CMD_LOOP) begin
        if (st_q == ST_PLAY) begin
          loop_d = 1'b1;
        end
      end else if (rx_byte_q == CMD_STOP) begin
        st_d = ST_IDLE; loop_d = 1'b0; start_d = 1'b0;
      end
      // Any other value falls through untouched
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE; seg_q <= '0; own_q <= OWN_SERIAL; loop_q <= 1'b0;
      vol_q <= VOL_RESET; start_q <= 1'b0; sel_q <= '0; selv_q <= 1'b0;
    end else begin
      st_q <= st_d; seg_q <= seg_d; own_q <= own_d; loop_q <= loop_d;
      vol_q <= vol_d; start_q <= start_d; sel_q <= sel_d; selv_q <= selv_d;
    end
  end

  assign play_start_o = start_q;
  assign seg_o        = seg_q;
  assign paused_o     = (st_q == ST_PAUSE);
  assign loop_o       = loop_q;
  assign volume_o     = vol_q;
  assign busy_o       = (st_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic rx_bad;
  assign rx_bad = rx_vld_q && rx_byte_q > SEG_LAST && rx_byte_q != CMD_LOOP && rx_byte_q != CMD_STOP &&
                  !(rx_byte_q >= VOL_FIRST && rx_byte_q <= VOL_LAST);

  property p_seg_play;
    @(posedge clock_i) disable iff (rst_i)
    rx_vld_q && rx_byte_q <= SEG_LAST |=> play_start_o && seg_o == $past(rx_byte_q);
  endproperty
  a_seg_play: assert property (p_seg_play) else $error("segment byte did not start playback");

  property p_volume;
    @(posedge clock_i) disable iff (rst_i)
    rx_vld_q && rx_byte_q >= VOL_FIRST && rx_byte_q <= VOL_LAST |=> volume_o == $past(rx_byte_q[2:0]);
  endproperty
  a_volume: assert property (p_volume) else $error("volume byte not applied");

  property p_loop;
    @(posedge clock_i) disable iff (rst_i)
    rx_vld_q && rx_byte_q == CMD_LOOP && st_q == ST_PLAY |=> loop_o;
  endproperty
  a_loop: assert property (p_loop) else $error("loop byte not applied");

  property p_stop;
    @(posedge clock_i) disable iff (rst_i)
    rx_vld_q && rx_byte_q == CMD_STOP |=> !busy_o && !play_start_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop byte did not stop");

  property p_busy_resp;
    @(posedge clock_i) disable iff (rst_i)
    rx_vld_q && rx_byte_q <= SEG_LAST |=> busy_o [*2];
  endproperty
  a_busy_resp: assert property (p_busy_resp) else $error("busy did not follow a play byte");

  property p_discard;
    @(posedge clock_i) disable iff (rst_i)
    rx_bad && !seg_end_i && fall_w == 3'h0 && rise_w == 3'h0 |=> $stable(st_q) && $stable(seg_o) && $stable(volume_o);
  endproperty
  a_discard: assert property (p_discard) else $error("unknown byte changed state");

  property p_three_wire;
    @(posedge clock_i) disable iff (rst_i)
    ctrl_mode_i == CM_THREE && !busy_o && !rx_vld_q |=> !busy_o && !play_start_o;
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("playback started without a byte");

  property p_pause_busy;
    @(posedge clock_i) disable iff (rst_i)
    $rose(paused_o) |-> busy_o && $past(busy_o);
  endproperty
  a_pause_busy: assert property (p_pause_busy) else $error("busy dropped on pause");

  property p_debounce;
    @(posedge clock_i) disable iff (rst_i)
    $changed(deb_q[0]) |-> $past(db_cnt_q[0]) == DEB_W'(DEB_CYC - 1);
  endproperty
  a_debounce: assert property (p_debounce) else $error("button changed before filter time");

  c_serial_play: cover property (@(posedge clock_i) disable iff (rst_i) rx_vld_q && rx_byte_q <= SEG_LAST);
  c_volume:      cover property (@(posedge clock_i) disable iff (rst_i) rx_vld_q && rx_byte_q == VOL_FIRST);
  c_pause:       cover property (@(posedge clock_i) disable iff (rst_i) $rose(paused_o));
  c_btn_play:    cover property (@(posedge clock_i) disable iff (rst_i) |fall_w ##1 play_start_o);

endmodule
`default_nettype wire

// ---- src/vpc_pkg.sv ----
// Constants and types shared by the voice playback control front end.
// Assumes a single 250 MHz system clock.
package vpc_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam longint     T_DEBOUNCE_PS   = 64'd10_000_000_000;
  localparam longint     T_FRAME_LOW_PS  = 64'd5_000_000_000;
  localparam longint     T_POWER_UP_PS   = 64'd17_000_000_000;
  localparam longint     T_BUSY_RESP_PS  = 64'd20_000_000_000;
  // Debounce is a least time, so round up
  localparam int unsigned DEBOUNCE_CYC    = int'((T_DEBOUNCE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Sync low accepted from half the nominal frame low time, rounded down
  localparam int unsigned SYNC_MIN_CYC    = int'((T_FRAME_LOW_PS / 2) / CLK_PERIOD_PS);

  // Widths
  localparam int unsigned DEB_W           = 22;
  localparam int unsigned OW_W            = 20;
  localparam logic [OW_W-1:0] OW_CNT_MAX  = 20'hFFFFF;

  // Command byte map
  localparam logic [7:0] SEG_FIRST        = 8'h00;
  localparam logic [7:0] SEG_LAST         = 8'hDB;
  localparam logic [7:0] VOL_FIRST        = 8'hE0;
  localparam logic [7:0] VOL_LAST         = 8'hE7;
  localparam logic [7:0] CMD_LOOP         = 8'hF2;
  localparam logic [7:0] CMD_STOP         = 8'hFE;
  localparam logic [2:0] VOL_RESET        = 3'h7;

  // Owner of the current playback; serial commands use the code above the buttons
  localparam logic [1:0] OWN_SERIAL       = 2'h3;

  typedef enum logic [1:0] {
    CM_BUTTON = 2'h0,
    CM_ONE    = 2'h1,
    CM_THREE  = 2'h2
  } vpc_ctrl_e;

  typedef enum logic [3:0] {
    TM_NONE       = 4'h0,
    TM_REP_EDGE   = 4'h1,
    TM_NOREP_EDGE = 4'h2,
    TM_LOOP_LVL   = 4'h3,
    TM_ONCE_LVL   = 4'h4,
    TM_NM_LOOP    = 4'h5,
    TM_PLAY_STOP  = 4'h6,
    TM_NEXT_NW    = 4'h7,
    TM_PREV_NW    = 4'h8,
    TM_NEXT_W     = 4'h9,
    TM_PREV_W     = 4'hA,
    TM_PAUSE      = 4'hB,
    TM_STOP       = 4'hC
  } vpc_trig_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PLAY  = 2'b01,
    ST_PAUSE = 2'b11
  } vpc_play_e;

  typedef enum logic [1:0] {
    OW_IDLE = 2'b00,
    OW_SYNC = 2'b01,
    OW_HI   = 2'b11,
    OW_LO   = 2'b10
  } vpc_ow_e;

endpackage

// ---- tb/voice_playback_control_tb.sv ----
// Self-checking bench for the voice playback control front end.
// Assumes shortened debounce and sync counts; the host model drives the port lines.
`timescale 1ns/100ps
`default_nettype none
module voice_playback_control_tb;
  import vpc_pkg::*;

  logic       clk     = 1'b0;
  logic       rst     = 1'b1;
  logic       seg_end = 1'b0;
  logic [1:0] mode    = 2'h1;
  logic [3:0] tma     = TM_NONE;
  logic [3:0] tmb     = TM_NONE;
  logic [3:0] tmc     = TM_NONE;
  logic [3:0] lines;
  logic       start;
  logic [7:0] seg;
  logic       paused;
  logic       loop;
  logic [2:0] vol;
  logic       busy;
  logic [7:0] r;
  logic [7:0] q [$];
  logic [7:0] bad [4] = '{8'hDC, 8'hE8, 8'hF0, 8'hFF};
  int         error_cnt = 0;
  int         samples_checked = 0;

  always #2 clk = ~clk;

  vpc_ctrl #(
    .DEB_CYC  (20),
    .SYNC_CYC (40)
  ) uut (
    .clock_i           (clk),
    .rst_i             (rst),
    .ctrl_mode_i       (mode),
    .trig_mode_a_i     (tma),
    .trig_mode_b_i     (tmb),
    .trig_mode_c_i     (tmc),
    .port_line_zero_i  (lines[0]),
    .port_line_one_i   (lines[1]),
    .port_line_two_i   (lines[2]),
    .port_line_three_i (lines[3]),
    .seg_end_i         (seg_end),
    .play_start_o      (start),
    .seg_o             (seg),
    .paused_o          (paused),
    .loop_o            (loop),
    .volume_o          (vol),
    .busy_o            (busy)
  );

  vpc_host_model #(.SYNC_LOW(80), .PH(8)) host (.clock_i(clk), .lines_o(lines));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Each start pulse takes the oldest expected segment
  always @(negedge clk) begin
    if (start === 1'b1) begin
      chk("start expected", 8'h01, 8'(q.size() > 0));
      if (q.size() > 0)
        chk("segment", q.pop_front(), seg);
      chk("busy at start", 8'h01, 8'(busy));
    end
  end

  task automatic settle;
    for (int i = 0; i < 400 && q.size() > 0; i++)
      @(negedge clk);
    if (q.size() > 0)
      chk("missing starts", 8'h00, 8'(q.size()));
    q.delete();
    host.wt(40);
  endtask

  task automatic send(input logic [7:0] b, input bit play);
    if (play)
      q.push_back(b);
    if (mode == 2'h1)
      host.ow_send(b);
    else
      host.tw_send(b);
    settle();
  endtask

  task automatic pp(input logic [7:0] s, input int k);
    q.push_back(s);
    host.press(k);
  endtask

  task automatic fin;
    seg_end = 1'b1;
    host.wt(1);
    seg_end = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(4 * 100_000);
    error_cnt++;
    give_verdict();
  end

  initial begin
    void'($urandom(14163));
    // Idle button modes are random: lines stay high, so no trigger may fire
    tmb = 4'($urandom_range(12, 0));
    tmc = 4'($urandom_range(12, 0));
    host.wt(8);
    rst = 1'b0;
    chk("volume", 8'h07, 8'(vol));
    chk("busy", 8'h00, 8'(busy));
    host.wt(50);
    send(8'h9C, 1'b1);
    chk("busy", 8'h01, 8'(busy));
    for (int v = 0; v < 8; v++) begin
      send(VOL_FIRST + 8'(v), 1'b0);
      chk("volume", 8'(v), 8'(vol));
    end
    send(CMD_LOOP, 1'b0);
    chk("loop", 8'h01, 8'(loop));
    q.push_back(8'h9C);
    fin();
    settle();
    send(CMD_STOP, 1'b0);
    chk("busy", 8'h00, 8'(busy));
    send(8'hE3, 1'b0);
    foreach (bad[i]) send(bad[i], 1'b0);
    chk("volume", 8'h03, 8'(vol));
    chk("busy", 8'h00, 8'(busy));
    send(SEG_LAST, 1'b1);
    r = 8'($urandom_range(219, 0));
    send(r, 1'b1);
    send(CMD_STOP, 1'b0);
    // Three-wire link with a live button that must be ignored
    mode = 2'h2;
    tma = 4'($urandom_range(12, 1));
    host.wt(10);
    send(8'h5A, 1'b1);
    host.press(0);
    send(CMD_STOP, 1'b0);
    chk("busy", 8'h00, 8'(busy));
    // Buttons: codes 0 and 3 both select button control
    mode = 2'(3 * $urandom_range(1, 0));
    tma = TM_REP_EDGE;
    host.wt(10);
    pp(8'h00, 0);
    pp(8'h00, 0);
    host.lvl(0, 1'b0, 5);
    host.lvl(0, 1'b1, 40);
    fin();
    settle();
    tmb = TM_NOREP_EDGE;
    pp(8'h01, 1);
    host.press(1);
    fin();
    pp(8'h01, 1);
    settle();
    tmc = TM_STOP;
    host.press(2);
    chk("busy", 8'h00, 8'(busy));
    host.press(2);
    tma = TM_PLAY_STOP;
    pp(8'h00, 0);
    host.press(0);
    chk("busy", 8'h00, 8'(busy));
    tma = TM_LOOP_LVL;
    q.push_back(8'h00);
    q.push_back(8'h00);
    host.lvl(0, 1'b0, 40);
    fin();
    host.wt(10);
    chk("busy", 8'h01, 8'(busy));
    host.lvl(0, 1'b1, 40);
    chk("busy", 8'h00, 8'(busy));
    settle();
    tma = TM_ONCE_LVL;
    q.push_back(8'h00);
    host.lvl(0, 1'b0, 40);
    fin();
    host.wt(10);
    chk("busy", 8'h00, 8'(busy));
    host.lvl(0, 1'b1, 40);
    settle();
    tma = TM_NM_LOOP;
    q.push_back(8'h00);
    q.push_back(8'h00);
    host.lvl(0, 1'b0, 40);
    fin();
    host.lvl(0, 1'b1, 40);
    chk("busy", 8'h01, 8'(busy));
    fin();
    host.wt(10);
    chk("busy", 8'h00, 8'(busy));
    settle();
    tma = TM_PAUSE;
    pp(8'h00, 0);
    host.press(0);
    chk("paused", 8'h01, 8'(paused));
    chk("busy", 8'h01, 8'(busy));
    host.press(0);
    chk("paused", 8'h00, 8'(paused));
    fin();
    settle();
    chk("busy", 8'h00, 8'(busy));
    tma = TM_NEXT_W;
    pp(8'h00, 0);
    pp(8'h01, 0);
    tma = TM_PREV_W;
    pp(8'h00, 0);
    pp(SEG_LAST, 0);
    tma = TM_NEXT_W;
    pp(8'h00, 0);
    tma = TM_PREV_NW;
    pp(8'h00, 0);
    tma = TM_PREV_W;
    pp(SEG_LAST, 0);
    tma = TM_NEXT_NW;
    pp(SEG_LAST, 0);
    settle();
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- tb/vpc_host_model.sv ----
// Host side model: drives the four port lines as buttons or as a serial host.
// Assumes callers enter its tasks at a falling clock edge; idle lines are pulled high.
`timescale 1ns/100ps
`default_nettype none
module vpc_host_model #(
  parameter int SYNC_LOW = 80,
  parameter int PH       = 8
) (
  // Clock
  input  wire logic       clock_i,
  // Port lines toward the device
  output logic      [3:0] lines_o
);
  initial lines_o = 4'hF;

  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic lvl(input int k, input logic v, input int n);
    lines_o[k] = v;
    wt(n);
  endtask

  task automatic press(input int k);
    lvl(k, 1'b0, 40);
    lvl(k, 1'b1, 40);
  endtask

  // Long opening low, then a high phase and a low phase per bit
  task automatic ow_send(input logic [7:0] b);
    lvl(3, 1'b0, SYNC_LOW);
    for (int i = 0; i < 8; i++) begin
      lvl(3, 1'b1, b[i] ? 3 * PH : PH);
      lvl(3, 1'b0, b[i] ? PH : 3 * PH);
    end
    lines_o[3] = 1'b1;
  endtask

  // Select low first; bit data changes while the clock is low, then data and select are released high with the clock high
  task automatic tw_send(input logic [7:0] b);
    lvl(2, 1'b0, 2 * PH);
    for (int i = 0; i < 8; i++) begin
      lines_o[3] = 1'b0;
      lvl(1, b[i], PH);
      lvl(3, 1'b1, PH);
    end
    lines_o[2] = 1'b1;
    lines_o[1] = 1'b1;
  endtask
endmodule
`default_nettype wire
